// ==== hdl/l2pd_check.sv ====
/*
 * Level two page descriptor check: decodes the selected descriptor,
 * translates an effective address and grants or faults one access.
 * Assumes the core raises chk_req for one cycle with stable qualifiers
 * and software loads descriptors over the plain register port.
 */
// Decided for this implementation: the placing of the registers and the plain strobed port.
`include "l2pd_defines.svh"

module l2pd_check import l2pd_pkg::*; #(
	parameter int SID_W = 8
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Access request from the core.
	input wire logic chk_req,
	input wire logic chk_ifetch,
	input wire logic chk_write,
	input wire logic chk_priv,
	input wire logic [31:0] chk_ea,
	// Check answer, one cycle after the request.
	output logic rsp_valid,
	output logic rsp_hit,
	output logic rsp_fault,
	output logic rsp_cacheable,
	output logic [31:0] rsp_pa
);

	// Software-visible state.
	logic [31:0] desc_fine_r;
	logic [31:0] desc_std_r;
	logic [3:0] ctrl_r;
	logic [SID_W-1:0] cur_sid_r;
	logic [SID_W-1:0] ent_sid_r;
	logic seen_r;
	logic [31:0] rdata_r;

	// Answer registers.
	logic valid_r;
	logic hit_r;
	logic fault_r;
	logic cache_r;
	logic [31:0] pa_r;

	// Decode wires.
	wire logic sel_fine;
	wire logic pcm;
	wire logic [1:0] ps;
	wire logic [31:0] desc;
	wire logic [19:0] rfn;
	wire logic [1:0] sub_idx;
	wire logic desc_sps;
	wire logic desc_sh;
	wire logic desc_ci;
	wire logic desc_v;
	wire logic desc_chg;
	wire logic desc_ppm;
	wire logic [3:0] qual;
	wire logic [1:0] fine_guard;
	wire logic [1:0] guard;
	wire logic sub_valid;
	wire logic qual_hit;
	wire logic qual_rsvd;
	wire logic sid_hit;
	wire logic hit;
	wire logic size_bad;
	wire logic wprot;
	wire logic fault;
	wire logic [31:0] mask;
	wire logic [31:0] pa_nxt;
	wire l2pd_page_t pg;

	// Register decode.
	wire logic wr_fine;
	wire logic wr_std;
	wire logic wr_ctrl;
	wire logic wr_space;
	wire logic wr_stat;
	wire logic seen_nxt;
	wire logic [31:0] rd_mux;

	l2pd_guard_if gif ();

	l2pd_guard u_guard (
		.g(gif)
	);

	// Control fields.
	assign sel_fine = ctrl_r[`L2PD_CTL_FINE];
	assign pcm = ctrl_r[`L2PD_CTL_PCM];
	assign ps = ctrl_r[`L2PD_CTL_PS_HI:`L2PD_CTL_PS_LO];

	// The layout select picks which descriptor word is in force.
	assign desc = sel_fine ? desc_fine_r : desc_std_r;
	assign rfn = desc[`L2PD_RFN_HI:`L2PD_RFN_LO];
	assign desc_sps = desc[`L2PD_SPS];
	assign desc_sh = desc[`L2PD_SH];
	assign desc_ci = desc[`L2PD_CI];
	assign desc_v = desc[`L2PD_V];
	assign desc_chg = desc[`L2PD_CHG];
	assign desc_ppm = desc[`L2PD_PPM];
	assign qual = desc[`L2PD_QUAL_HI:`L2PD_QUAL_LO];

	// Address bits 11:10 name the 1K subpage within a 4K page.
	assign sub_idx = chk_ea[11:10];

	// Page size from the first-level field and the big-page flag.
	// A big-page flag at 0 beside a large size field is inconsistent
	// and is refused rather than guessed at.
	assign pg = (ps == `L2PD_PS_SMALL) ? (desc_sps ? PG_16K : PG_4K) :
		(ps == `L2PD_PS_512K && desc_sps) ? PG_512K :
		(ps == `L2PD_PS_8M && desc_sps) ? PG_8M : PG_BAD;
	assign size_bad = (pg == PG_BAD);

	// Frame bits above the page offset come from the descriptor.
	assign mask = (pg == PG_16K) ? `L2PD_MASK_16K :
		(pg == PG_512K) ? `L2PD_MASK_512K :
		(pg == PG_8M) ? `L2PD_MASK_8M : `L2PD_MASK_4K;
	assign pa_nxt = ({rfn, 12'h000} & ~mask) | (chk_ea & mask);

	// Fine layout: one guard per subpage, first subpage in bits 11:10.
	assign fine_guard = (sub_idx == 2'h0) ? desc[11:10] :
		(sub_idx == 2'h1) ? desc[9:8] :
		(sub_idx == 2'h2) ? desc[7:6] : desc[5:4];
	assign guard = sel_fine ? fine_guard : desc[`L2PD_PP_HI:`L2PD_PP_HI-1];

	// Subpage valid flag, the first subpage in the top qualifier bit.
	assign sub_valid = qual[2'h3 - sub_idx];

	// Privilege qualifier used when compare mode is on.
	assign qual_hit = (qual == `L2PD_Q_PRIV && chk_priv) ||
		(qual == `L2PD_Q_PROB && !chk_priv) ||
		(qual == `L2PD_Q_BOTH);
	assign qual_rsvd = qual != `L2PD_Q_PRIV && qual != `L2PD_Q_PROB &&
		qual != `L2PD_Q_BOTH;

	// Space identifier match unless the entry is global.
	assign sid_hit = desc_sh || (ent_sid_r == cur_sid_r);

	// A reserved qualifier still matches so that it surfaces as a fault.
	assign hit = sid_hit && (sel_fine || !pcm || qual_hit || qual_rsvd);

	// Only the standard layout carries a change bit.
	assign wprot = !sel_fine && chk_write && !chk_ifetch && !desc_chg;

	// Hand the selected guard to the decoder.
	assign gif.fine = sel_fine;
	assign gif.guard = guard;
	assign gif.guard_encoding_sel = desc_ppm;
	assign gif.ifetch = chk_ifetch;
	assign gif.write = chk_write && !chk_ifetch;
	assign gif.priv = chk_priv;

	// Any denial on a matching entry is reported as a fault.
	assign fault = hit && (desc_v || size_bad || !gif.allow || gif.reserved ||
		wprot || (!sel_fine && pcm && qual_rsvd) ||
		(!sel_fine && !pcm && !sub_valid));

	// Answer registers load on each request; valid is a single pulse.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			valid_r <= 1'b0;
			hit_r <= 1'b0;
			fault_r <= 1'b0;
			cache_r <= 1'b0;
			pa_r <= 32'h0000_0000;
		end else begin
			valid_r <= chk_req;
			if (chk_req) begin
				hit_r <= hit;
				fault_r <= fault;
				cache_r <= !desc_ci;
				pa_r <= pa_nxt;
			end
		end
	end

	assign rsp_valid = valid_r;
	assign rsp_hit = hit_r;
	assign rsp_fault = fault_r;
	assign rsp_cacheable = cache_r;
	assign rsp_pa = pa_r;

	// Write strobes per register.
	assign wr_fine = reg_wr && reg_addr == `L2PD_OFS_DESC_FINE;
	assign wr_std = reg_wr && reg_addr == `L2PD_OFS_DESC_STD;
	assign wr_ctrl = reg_wr && reg_addr == `L2PD_OFS_CTRL;
	assign wr_space = reg_wr && reg_addr == `L2PD_OFS_SPACE;
	assign wr_stat = reg_wr && reg_addr == `L2PD_OFS_STATUS;

	// Sticky fault flag: a new fault beats a clear in the same cycle.
	assign seen_nxt = (chk_req && fault) ||
		(seen_r && !(wr_stat && reg_wdata[`L2PD_ST_SEEN]));

	// Read selection; unmapped offsets read as zero.
	assign rd_mux = (reg_addr == `L2PD_OFS_DESC_FINE) ? desc_fine_r :
		(reg_addr == `L2PD_OFS_DESC_STD) ? desc_std_r :
		(reg_addr == `L2PD_OFS_CTRL) ? {28'h000_0000, ctrl_r} :
		(reg_addr == `L2PD_OFS_SPACE) ?
			32'({ent_sid_r, 8'h00, cur_sid_r}) :
		(reg_addr == `L2PD_OFS_STATUS) ?
			{28'h000_0000, seen_r, cache_r, fault_r, hit_r} :
		32'h0000_0000;

	// Software registers.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			desc_fine_r <= `L2PD_RST_DESC;
			desc_std_r <= `L2PD_RST_DESC;
			ctrl_r <= `L2PD_RST_CTRL;
			cur_sid_r <= '0;
			ent_sid_r <= '0;
			seen_r <= 1'b0;
		end else begin
			if (wr_fine)
				desc_fine_r <= reg_wdata;
			if (wr_std)
				desc_std_r <= reg_wdata;
			if (wr_ctrl)
				ctrl_r <= reg_wdata[3:0];
			if (wr_space) begin
				cur_sid_r <= reg_wdata[SID_W-1:0];
				ent_sid_r <= reg_wdata[16+SID_W-1:16];
			end
			seen_r <= seen_nxt;
		end
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			rdata_r <= 32'h0000_0000;
		else
			rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
	end

	assign reg_rdata = rdata_r;

	// Checks on the decode and the register port, all in the one clock domain.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_FRAME_FULL: assert property (
		rsp_valid && $past(pg) == PG_4K |-> rsp_pa[31:12] == $past(rfn))
		else $error("4K frame number not taken whole");

	AST_FRAME_8M: assert property (
		chk_req && pg == PG_8M |=>
		((rsp_pa ^ $past(chk_ea)) & `L2PD_MASK_8M) == 32'h0000_0000)
		else $error("8M offset not taken from the address");

	AST_FRAME_512K: assert property (
		chk_req && pg == PG_512K |=>
		rsp_pa[31:19] == $past(rfn[19:7]))
		else $error("512K frame bits wrong");

	AST_SPACE_MISS: assert property (
		chk_req && !desc_sh && ent_sid_r != cur_sid_r |=> rsp_valid && !rsp_hit)
		else $error("hit despite identifier mismatch");

	AST_CACHE: assert property (
		chk_req ##1 rsp_valid |-> rsp_cacheable == !$past(desc_ci))
		else $error("cacheable flag does not follow inhibit bit");

	AST_INVALID: assert property (
		chk_req && hit && desc_v |=> rsp_fault)
		else $error("invalid page did not fault");

	AST_FINE_NOFETCH: assert property (
		chk_req && hit && sel_fine && chk_ifetch && fine_guard == 2'h0 |=> rsp_fault)
		else $error("fetch allowed on closed subpage");

	AST_FINE_PROBREAD: assert property (
		chk_req && sel_fine && !chk_ifetch && !chk_write && !chk_priv &&
		fine_guard == 2'h2 |-> gif.allow)
		else $error("problem read refused on code 10");

	AST_STD_FETCH: assert property (
		chk_req && !sel_fine && !desc_ppm && chk_ifetch && guard != 2'h0 |-> gif.allow)
		else $error("standard fetch refused on open code");

	AST_EXT_WRITE: assert property (
		chk_req && hit && !sel_fine && desc_ppm && chk_write && !chk_ifetch |=> rsp_fault)
		else $error("write allowed under extended coding");

	AST_WPROT: assert property (
		chk_req && hit && wprot |=> rsp_fault)
		else $error("write to unchanged page not faulted");

	AST_SUB_INVALID: assert property (
		chk_req && hit && !sel_fine && !pcm && !sub_valid |=> rsp_fault)
		else $error("invalid subpage did not fault");

	AST_QUAL_PRIV: assert property (
		chk_req && !sel_fine && pcm && qual == `L2PD_Q_PRIV && !chk_priv |=> !rsp_hit)
		else $error("problem access hit a privileged-only entry");

	AST_SIZE_RSVD: assert property (
		chk_req && hit && ps == 2'h2 |=> rsp_fault)
		else $error("reserved size field not faulted");

	AST_READ_ONE: assert property (
		reg_rd && reg_addr == `L2PD_OFS_CTRL |=> reg_rdata == {28'h000_0000, $past(ctrl_r)})
		else $error("control read back wrong");

	// The answer strobe follows the request one cycle later and never shows without a request.
	AST_VALID_ONE: assert property (
		!chk_req |=> !rsp_valid)
		else $error("answer valid without a request");

	// Read data rest at zero outside the cycle after a read strobe.
	AST_RDATA_IDLE: assert property (
		!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data not idle");

	// A fault always reaches the sticky flag, even against a clear.
	AST_SEEN_SET: assert property (
		chk_req && fault |=> seen_r)
		else $error("fault not recorded in status");

endmodule : l2pd_check

// ==== hdl/l2pd_defines.svh ====
/*
 * Offsets, field positions, reset values and masks of the level two
 * descriptor check. Assumes descriptor bit 0 is the most significant bit.
 */
`ifndef L2PD_DEFINES_SVH
`define L2PD_DEFINES_SVH

// Register byte offsets.
`define L2PD_OFS_DESC_FINE 8'h00
`define L2PD_OFS_DESC_STD 8'h04
`define L2PD_OFS_CTRL 8'h08
`define L2PD_OFS_SPACE 8'h0c
`define L2PD_OFS_STATUS 8'h10

// Descriptor fields, written as little-endian bit indices.
`define L2PD_RFN_HI 31
`define L2PD_RFN_LO 12
`define L2PD_PP_HI 11
`define L2PD_PPM 9
`define L2PD_CHG 8
`define L2PD_QUAL_HI 7
`define L2PD_QUAL_LO 4
`define L2PD_SPS 3
`define L2PD_SH 2
`define L2PD_CI 1
`define L2PD_V 0

// Control register fields.
`define L2PD_CTL_PS_HI 1
`define L2PD_CTL_PS_LO 0
`define L2PD_CTL_PCM 2
`define L2PD_CTL_FINE 3

// Status register fields.
`define L2PD_ST_HIT 0
`define L2PD_ST_FAULT 1
`define L2PD_ST_CACHE 2
`define L2PD_ST_SEEN 3

// Reset values.
`define L2PD_RST_DESC 32'h0000_0000
`define L2PD_RST_CTRL 4'h0

// First-level size codes and subpage qualifiers.
`define L2PD_PS_SMALL 2'h0
`define L2PD_PS_512K 2'h1
`define L2PD_PS_8M 2'h3
`define L2PD_Q_PRIV 4'h8
`define L2PD_Q_PROB 4'h4
`define L2PD_Q_BOTH 4'hc

// Effective-address offset masks per page size.
`define L2PD_MASK_4K 32'h0000_0fff
`define L2PD_MASK_16K 32'h0000_3fff
`define L2PD_MASK_512K 32'h0007_ffff
`define L2PD_MASK_8M 32'h007f_ffff

`endif

// ==== hdl/l2pd_guard.sv ====
/*
 * Combinational decoder of a two-bit protection field into a grant.
 * Assumes the caller has already picked the field for the access.
 */
module l2pd_guard import l2pd_pkg::*; (
	// Decode request and answer.
	l2pd_guard_if.dec g
);
	wire logic [1:0] c;
	wire logic rd_ok;
	wire logic fine_allow;
	wire logic ext_allow;
	wire logic ppc_allow;

	assign c = g.guard;
	assign rd_ok = !g.write;

	// Subpage fields: 00 denies all, 01 is privileged only, 10 and 11 open up problem state.
	assign fine_allow = g.ifetch ?
		(c == 2'h1 ? g.priv : c[1]) :
		(c == 2'h1 ? g.priv :
		 c == 2'h2 ? (g.priv || rd_ok) :
		 c == 2'h3);

	// Extended coding grants privileged execute or read only on 01.
	assign ext_allow = (c == 2'h1) && g.priv && (g.ifetch || rd_ok);

	// Standard coding.
	assign ppc_allow = g.ifetch ?
		(c == 2'h0 ? g.priv : 1'b1) :
		(c == 2'h0 ? (g.priv && rd_ok) :
		 c == 2'h1 ? (g.priv || rd_ok) :
		 c == 2'h2 ? 1'b1 : rd_ok);

	// The layout and mode bit choose the table in force.
	assign g.allow = g.fine ? fine_allow : (g.guard_encoding_sel ? ext_allow : ppc_allow);
	assign g.reserved = !g.fine && g.guard_encoding_sel && c[1];
endmodule : l2pd_guard

// ==== hdl/l2pd_guard_if.sv ====
/*
 * Carrier between the check top and its protection decoder.
 * Assumes both ends sit on the same clock.
 */
interface l2pd_guard_if;
	logic fine;
	logic [1:0] guard;
	logic guard_encoding_sel;
	logic ifetch;
	logic write;
	logic priv;
	logic allow;
	logic reserved;

	modport user (output fine, guard, guard_encoding_sel, ifetch, write, priv, input allow, reserved);
	modport dec (input fine, guard, guard_encoding_sel, ifetch, write, priv, output allow, reserved);
endinterface : l2pd_guard_if

// ==== hdl/l2pd_pkg.sv ====
/*
 * Types shared by the descriptor check modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package l2pd_pkg;

	// Decoded page size of the entry under check.
	typedef enum logic [2:0] {PG_4K, PG_16K, PG_512K, PG_8M, PG_BAD} l2pd_page_t;

endpackage : l2pd_pkg

// ==== tb/l2pd_core_model.sv ====
/*
 * Core side model: issues one access check and collects the answer.
 * Assumes the check answers exactly one cycle after the request.
 */
module l2pd_core_model (
	// Clock.
	input wire logic sys_clk,
	// Request towards the check.
	output logic chk_req,
	output logic chk_ifetch,
	output logic chk_write,
	output logic chk_priv,
	output logic [31:0] chk_ea,
	// Answer from the check.
	input wire logic rsp_valid,
	input wire logic rsp_hit,
	input wire logic rsp_fault,
	input wire logic rsp_cacheable,
	input wire logic [31:0] rsp_pa
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle request lines at time zero.
	initial begin
		chk_req = 1'b0;
		chk_ifetch = 1'b0;
		chk_write = 1'b0;
		chk_priv = 1'b0;
		chk_ea = 32'h0;
	end

	// Qualifiers are inverted after the request edge, so a check that
	// samples them late sees wrong values rather than a stale match.
	task automatic req(input logic i, input logic w, input logic p, input logic [31:0] ea,
		output logic v, output logic h, output logic f, output logic c,
		output logic [31:0] pa);
		@(posedge sys_clk);
		chk_req <= 1'b1;
		chk_ifetch <= i;
		chk_write <= w;
		chk_priv <= p;
		chk_ea <= ea;
		@(posedge sys_clk);
		chk_req <= 1'b0;
		chk_ifetch <= ~i;
		chk_write <= ~w;
		chk_priv <= ~p;
		chk_ea <= ~ea;
		#1;
		v = rsp_valid;
		h = rsp_hit;
		f = rsp_fault;
		c = rsp_cacheable;
		pa = rsp_pa;
	endtask : req
endmodule : l2pd_core_model

// ==== tb/tb_top.sv ====
/*
 * Bench for the descriptor check: registers over the plain port,
 * accesses through the core model, every answer judged here.
 * Assumes reset clears every register and output to zero.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic chk_req, chk_ifetch, chk_write, chk_priv;
	logic [31:0] chk_ea, rsp_pa;
	logic rsp_valid, rsp_hit, rsp_fault, rsp_cacheable;
	logic v, h, f, c;
	logic [31:0] p;
	int fails = 0;
	int checks_done = 0;

	// Design and the core standing in front of it.
	l2pd_check uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.chk_req(chk_req), .chk_ifetch(chk_ifetch), .chk_write(chk_write),
		.chk_priv(chk_priv), .chk_ea(chk_ea), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit),
		.rsp_fault(rsp_fault), .rsp_cacheable(rsp_cacheable), .rsp_pa(rsp_pa));
	l2pd_core_model core (.sys_clk(sys_clk), .chk_req(chk_req), .chk_ifetch(chk_ifetch),
		.chk_write(chk_write), .chk_priv(chk_priv), .chk_ea(chk_ea),
		.rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_fault(rsp_fault),
		.rsp_cacheable(rsp_cacheable), .rsp_pa(rsp_pa));

	// Free running 100 MHz clock.
	always #5 sys_clk = ~sys_clk;

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, seen);
			fails++;
		end
	endtask : chk

	// Each bus task drops its strobe on its second edge and returns without waiting for another.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", reg_rdata, exp);
	endtask : rd

	task automatic go(input logic i, input logic w, input logic pr, input logic [31:0] ea);
		core.req(i, w, pr, ea, v, h, f, c, p);
		chk("valid", v, 1'b1);
	endtask : go

	// Grant tables for the standard layout and the fine layout.
	function automatic logic std_ok(logic guard_encoding_sel, logic [1:0] pp, logic i, logic w, logic pr);
		if (i) begin
			return guard_encoding_sel ? (pp == 2'h1 && pr) : (pp != 2'h0 || pr);
		end
		if (guard_encoding_sel) begin
			return pp == 2'h1 && pr && !w;
		end
		return pp == 2'h0 ? pr && !w : pp == 2'h1 ? pr || !w : pp == 2'h2 ? 1'b1 : !w;
	endfunction : std_ok

	function automatic logic fine_ok(logic [1:0] g, logic i, logic w, logic pr);
		if (i) begin
			return g[1] || (g == 2'h1 && pr);
		end
		return g == 2'h0 ? 1'b0 : g == 2'h1 ? pr : g == 2'h2 ? pr || !w : 1'b1;
	endfunction : fine_ok

	task automatic t_reset();
		chk("rst_out", {rsp_valid, rsp_hit, rsp_fault, rsp_cacheable}, 4'h0);
		chk("rst_pa", rsp_pa, 32'h0);
		for (int a = 0; a < 5; a++) begin
			rd(8'(a * 4), 32'h0);
		end
		$display("t_reset done");
	endtask : t_reset

	// Kinds k: 0,1 fetch, 2,3 read, 4,5 write; odd k is privileged.
	task automatic t_std();
		logic ok;
		for (int e = 0; e < 8; e++) begin
			wr(8'h04, {20'h12345, e[1:0], e[2], 1'b1, 4'hf, 4'b0100});
			for (int k = 0; k < 6; k++) begin
				go(k < 2, k > 3, k[0], 32'h0);
				ok = std_ok(e[2], e[1:0], k < 2, k > 3, k[0]);
				chk("std_fault", f, !ok);
			end
		end
		wr(8'h04, {20'h12345, 2'h2, 2'b00, 4'hf, 4'b0100});
		go(1'b0, 1'b1, 1'b1, 32'h0);
		chk("wp_write", f, 1'b1);
		go(1'b0, 1'b0, 1'b1, 32'h0);
		chk("wp_read", f, 1'b0);
		go(1'b1, 1'b1, 1'b1, 32'h0);
		chk("wp_fetch", f, 1'b0);
		$display("t_std done");
	endtask : t_std

	task automatic t_size();
		logic [31:0] m [6] = '{32'hfff, 32'h3fff, 32'h7ffff, 32'h7fffff, 32'h0, 32'h0};
		logic [1:0] ps [6] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h2, 2'h1};
		logic [5:0] sp = 6'b011110;
		for (int k = 0; k < 6; k++) begin
			wr(8'h08, {30'h0, ps[k]});
			wr(8'h04, {20'habcde, 2'h2, 2'b01, 4'hf, sp[k], 3'b100});
			go(1'b0, 1'b0, 1'b1, 32'h13579bdf);
			chk("size_fault", f, k > 3);
			if (k < 4) begin
				chk("pa", p, (32'habcde000 & ~m[k]) | (32'h13579bdf & m[k]));
			end
		end
		$display("t_size done");
	endtask : t_size

	task automatic t_fine();
		wr(8'h08, 32'h8);
		wr(8'h00, {20'h0a0a0, 8'h1b, 4'b0100});
		for (int q = 0; q < 4; q++) begin
			for (int k = 0; k < 6; k++) begin
				go(k < 2, k > 3, k[0], {20'h0, q[1:0], 10'h0});
				chk("fine_fault", f, !fine_ok(q[1:0], k < 2, k > 3, k[0]));
			end
			chk("fine_pa", p, {20'h0a0a0, q[1:0], 10'h0});
		end
		$display("t_fine done");
	endtask : t_fine

	task automatic t_attr();
		wr(8'h08, 32'h0);
		wr(8'h0c, 32'h005a005a);
		wr(8'h04, {20'h1, 2'h2, 2'b01, 4'hf, 4'b0000});
		go(1'b0, 1'b0, 1'b1, 32'h0);
		chk("id_hit", h, 1'b1);
		chk("cached", c, 1'b1);
		wr(8'h0c, 32'h005b005a);
		go(1'b0, 1'b0, 1'b1, 32'h0);
		chk("id_miss", {h, f}, 2'b00);
		wr(8'h04, {20'h1, 2'h2, 2'b01, 4'hf, 4'b0110});
		go(1'b0, 1'b0, 1'b1, 32'h0);
		chk("shared", h, 1'b1);
		chk("uncached", c, 1'b0);
		wr(8'h04, {20'h1, 2'h2, 2'b01, 4'hf, 4'b0101});
		go(1'b0, 1'b0, 1'b1, 32'h0);
		chk("invalid", f, 1'b1);
		rd(8'h10, 32'hf);
		wr(8'h10, 32'h8);
		rd(8'h10, 32'h7);
		wr(8'h14, 32'hffffffff);
		rd(8'h14, 32'h0);
		$display("t_attr done");
	endtask : t_attr

	task automatic t_sub();
		logic [3:0] qv [4] = '{4'h8, 4'h4, 4'hc, 4'h2};
		wr(8'h04, {20'h1, 2'h2, 2'b01, 4'b1010, 4'b0100});
		for (int q = 0; q < 4; q++) begin
			go(1'b0, 1'b0, 1'b1, {20'h0, q[1:0], 10'h0});
			chk("sub_valid", f, q[0]);
		end
		wr(8'h08, 32'h4);
		for (int n = 0; n < 4; n++) begin
			wr(8'h04, {20'h1, 2'h2, 2'b01, qv[n], 4'b0100});
			for (int r = 0; r < 2; r++) begin
				go(1'b0, 1'b0, r[0], 32'h0);
				chk("qual_hit", h, n == 0 ? r[0] : n == 1 ? !r[0] : 1'b1);
				chk("qual_fault", f, n == 3);
			end
		end
		$display("t_sub done");
	endtask : t_sub

	// Watchdog: a hang is counted as a mismatch.
	initial begin
		#500000;
		fails++;
		finish_test();
	end

	// Main sequence.
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_std();
		t_size();
		t_fine();
		t_attr();
		t_sub();
		finish_test();
	end
endmodule : tb_top
